//--- rtl/ccpb_top.sv
`timescale 1ns/10ps
// What this block does
// - compare value checked against selected 16-bit timer
// - match applies pin action and sets event flag
// - codes toggle, start-low-set, start-high-clear
// - zero control write clears compare latch low
// - code 1010 only sets the event flag
// - code 1011 pulse clears assigned timer
// - trigger starts conversion if converter enabled
// - four pwm outputs, 10-bit duty
// - time base is timer byte plus two bits
// - config field picks single, half, full bridge
// - single mode drives only steered outputs
// - pwm waits for new period before starting
// - half bridge: A pwm, B complement
// - dead band delays each rising edge
// - forward: A active, D modulated
// - reverse: C active, B modulated
// - direction flip: B/D off, A/C swap early
// - early swap one prescale of oscillator ticks
// - no dead band in full bridge
// - low mode bits set pair polarities
// - codes 1100-1111 are pwm with polarity
// - period flag set as each period after the first begins
module ccpb_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // compare time bases and converter
    input wire logic [15:0] time_base_one,
    input wire logic [15:0] time_base_three,
    input wire logic adc_enabled,
    output logic clear_time_base_one,
    output logic clear_time_base_three,
    output logic adc_start,
    // status
    output logic module_event_flag,
    output logic period_timer_flag,
    // output pins
    output ccpb_pkg::ccpb_pins_s pin_out,
    output ccpb_pkg::ccpb_pins_s pin_oe
);
    import ccpb_pkg::*;

    // ============================================================
    // registers written by software
    logic [7:0] ctrl_reg;        // cfg, duty low bits, mode
    logic [15:0] cmp_reg;        // compare_value_pair
    logic [7:0] duty_reg;        // duty bits 9:2
    logic [7:0] period_reg;
    logic [6:0] dead_reg;        // dead_band_count
    logic [3:0] steer_reg;       // single mode steering a..d in bits 0..3
    logic [3:0] tcfg_reg;        // on, select, prescale
    logic [3:0] dir_reg;         // pin_direction_bits, 1 = input

    // ============================================================
    // internal state
    logic evt_flag_reg;
    logic per_flag_reg;
    logic cmp_latch_reg;         // compare output latch, not the port latch
    logic match_prev_reg;
    logic [1:0] q_reg;           // quarter cycle of the instruction clock
    logic [9:0] duty_act_reg;    // duty taken at period start
    logic dir_act_reg;           // direction taken at period start
    ccpb_pwm_e pwm_state_reg;
    ccpb_pwm_e pwm_state_next;

    // ============================================================
    // decoded fields
    logic [3:0] mode;
    logic [1:0] cfg;
    logic pwm_mode;
    logic cmp_mode;
    logic [15:0] sel_count;
    logic match_now;
    logic match_evt;
    logic ctrl_wr;
    logic stat_wr;
    logic [7:0] tcnt;
    logic [9:0] tb;
    logic per_start;
    logic early;
    logic raw_pwm;
    logic db_a;
    logic db_b;
    logic cycle_tick;
    logic dir_pending;
    ccpb_pins_s act;              // active-high pin levels before polarity
    ccpb_pins_s use_pins;         // pins owned by the current mode

    assign mode = ctrl_reg[3:0];
    assign cfg = ctrl_reg[CCPB_CTRL_CFG_LSB +: 2];
    assign pwm_mode = (mode[3:2] == 2'h3);
    assign cmp_mode = (mode == CCPB_MODE_TOGGLE) || (mode[3:2] == 2'h2);
    assign ctrl_wr = reg_wr && (reg_addr == CCPB_ADDR_CTRL);
    assign stat_wr = reg_wr && (reg_addr == CCPB_ADDR_STAT);
    assign cycle_tick = (q_reg == 2'h3);
    assign dir_pending = (cfg[1] != dir_act_reg);

    // ============================================================
    // register writes
    // one process for all the software registers keeps the decode readable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CCPB_RST_ZERO;
            cmp_reg <= 16'h0000;
            duty_reg <= CCPB_RST_ZERO;
            period_reg <= CCPB_RST_PERIOD;
            dead_reg <= 7'h00;
            steer_reg <= 4'h1;
            tcfg_reg <= 4'h0;
            dir_reg <= CCPB_RST_DIR;
        end else if (reg_wr) begin
            unique case (reg_addr)
                CCPB_ADDR_CTRL: ctrl_reg <= reg_wdata;
                CCPB_ADDR_CMP_LO: cmp_reg[7:0] <= reg_wdata;
                CCPB_ADDR_CMP_HI: cmp_reg[15:8] <= reg_wdata;
                CCPB_ADDR_DUTY: duty_reg <= reg_wdata;
                CCPB_ADDR_PERIOD: period_reg <= reg_wdata;
                CCPB_ADDR_DEAD: dead_reg <= reg_wdata[6:0];
                CCPB_ADDR_STEER: steer_reg <= reg_wdata[3:0];
                CCPB_ADDR_TCFG: tcfg_reg <= reg_wdata[3:0];
                CCPB_ADDR_DIR: dir_reg <= reg_wdata[3:0];
                default: ;  // status and count handled elsewhere
            endcase
        end
    end

    // ============================================================
    // register reads, data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                CCPB_ADDR_CTRL: reg_rdata <= ctrl_reg;
                CCPB_ADDR_CMP_LO: reg_rdata <= cmp_reg[7:0];
                CCPB_ADDR_CMP_HI: reg_rdata <= cmp_reg[15:8];
                CCPB_ADDR_DUTY: reg_rdata <= duty_reg;
                CCPB_ADDR_PERIOD: reg_rdata <= period_reg;
                CCPB_ADDR_DEAD: reg_rdata <= {1'b0, dead_reg};
                CCPB_ADDR_STEER: reg_rdata <= {4'h0, steer_reg};
                CCPB_ADDR_TCFG: reg_rdata <= {4'h0, tcfg_reg};
                CCPB_ADDR_DIR: reg_rdata <= {4'h0, dir_reg};
                CCPB_ADDR_STAT: reg_rdata <= {6'h00, per_flag_reg, evt_flag_reg};
                CCPB_ADDR_TCNT: reg_rdata <= tcnt;
                default: reg_rdata <= 8'h00;  // unmapped reads as zero
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ============================================================
    // compare against the selected time base
    // the timer must be synchronous to sys_clk or matches may be missed
    assign sel_count = tcfg_reg[CCPB_TCFG_SEL] ? time_base_three : time_base_one;
    assign match_now = cmp_mode && (sel_count == cmp_reg);
    // only the first cycle of an equal run counts, so a slow timer fires once
    assign match_evt = match_now && !match_prev_reg;

    // remembers equality from the previous cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_now;
        end
    end

    // compare output latch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_latch_reg <= 1'b0;
        end else if (ctrl_wr && (reg_wdata == CCPB_RST_ZERO)) begin
            cmp_latch_reg <= 1'b0;
        end else if (ctrl_wr && (reg_wdata[3:0] == CCPB_MODE_SET)) begin
            cmp_latch_reg <= 1'b0;
        end else if (ctrl_wr && (reg_wdata[3:0] == CCPB_MODE_CLEAR)) begin
            cmp_latch_reg <= 1'b1;
        end else if (match_evt) begin
            // pin action chosen by the mode
            unique case (mode)
                CCPB_MODE_TOGGLE: cmp_latch_reg <= !cmp_latch_reg;
                CCPB_MODE_SET: cmp_latch_reg <= 1'b1;
                CCPB_MODE_CLEAR: cmp_latch_reg <= 1'b0;
                default: ;  // soft and trigger modes leave the pin
            endcase
        end
    end

    // sticky flags; hardware set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_flag_reg <= 1'b0;
            per_flag_reg <= 1'b0;
        end else begin
            if (match_evt) begin
                evt_flag_reg <= 1'b1;
            end else if (stat_wr && reg_wdata[CCPB_STAT_EVT]) begin
                evt_flag_reg <= 1'b0;
            end
            if (per_start) begin
                per_flag_reg <= 1'b1;
            end else if (stat_wr && reg_wdata[CCPB_STAT_PER]) begin
                per_flag_reg <= 1'b0;
            end
        end
    end

    // special event trigger pulses
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clear_time_base_one <= 1'b0;
            clear_time_base_three <= 1'b0;
            adc_start <= 1'b0;
        end else begin
            clear_time_base_one <= match_evt && (mode == CCPB_MODE_TRIG)
                && !tcfg_reg[CCPB_TCFG_SEL];
            clear_time_base_three <= match_evt && (mode == CCPB_MODE_TRIG)
                && tcfg_reg[CCPB_TCFG_SEL];
            // a disabled converter ignores the trigger
            adc_start <= match_evt && (mode == CCPB_MODE_TRIG) && adc_enabled;
        end
    end

    // ============================================================
    // pwm time base
    ccpb_period_base u_period (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(tcfg_reg[CCPB_TCFG_ON]),
        .period(period_reg),
        .presc_sel(tcfg_reg[1:0]),
        .count(tcnt),
        .time_base(tb),
        .period_start(per_start),
        .early_window(early)
    );

    // instruction cycle phase for dead-band counting
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= 2'h0;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    // start-up: enable only takes effect at a period boundary
    always_comb begin
        pwm_state_next = pwm_state_reg;
        unique case (pwm_state_reg)
            CCPB_PWM_IDLE: if (pwm_mode) pwm_state_next = CCPB_PWM_WAIT;
            CCPB_PWM_WAIT: begin
                if (!pwm_mode) begin
                    pwm_state_next = CCPB_PWM_IDLE;
                end else if (per_start) begin
                    pwm_state_next = CCPB_PWM_RUN;
                end
            end
            CCPB_PWM_RUN: if (!pwm_mode) pwm_state_next = CCPB_PWM_IDLE;
            default: pwm_state_next = CCPB_PWM_IDLE;
        endcase
    end

    // state updates every cycle; duty and direction are taken at each period start and while idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_state_reg <= CCPB_PWM_IDLE;
            duty_act_reg <= 10'h000;
            dir_act_reg <= 1'b0;
        end else begin
            pwm_state_reg <= pwm_state_next;
            if (per_start || (pwm_state_reg == CCPB_PWM_IDLE)) begin
                duty_act_reg <= {duty_reg, ctrl_reg[CCPB_CTRL_DLSB_LSB +: 2]};
                dir_act_reg <= cfg[1];
            end
        end
    end

    // 10-bit duty comparison
    assign raw_pwm = (pwm_state_reg == CCPB_PWM_RUN) && (tb < duty_act_reg);

    // dead band only in half bridge
    ccpb_dead_band u_db_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(cfg == CCPB_CFG_HALF),
        .cycle_tick(cycle_tick),
        .delay(dead_reg),
        .sig_in(raw_pwm),
        .sig_out(db_a)
    );

    ccpb_dead_band u_db_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(cfg == CCPB_CFG_HALF),
        .cycle_tick(cycle_tick),
        .delay(dead_reg),
        .sig_in((pwm_state_reg == CCPB_PWM_RUN) && !raw_pwm),
        .sig_out(db_b)
    );

    // ============================================================
    // output mode mapping, active-high levels
    always_comb begin
        act = '0;
        use_pins = '0;
        unique case (cfg)
            CCPB_CFG_SINGLE: begin
                act = {4{raw_pwm}} & {steer_reg[0], steer_reg[1], steer_reg[2],
                    steer_reg[3]};
                use_pins = {steer_reg[0], steer_reg[1], steer_reg[2], steer_reg[3]};
            end
            CCPB_CFG_HALF: begin
                act.a = db_a;
                act.b = db_b;
                use_pins = 4'b1100;
            end
            default: begin
                use_pins = 4'b1111;
                if (dir_pending && early) begin
                    // next direction drives early; modulated pair held off
                    act.a = !cfg[1];
                    act.c = cfg[1];
                end else if (dir_pending) begin
                    act.a = !dir_act_reg;
                    act.c = dir_act_reg;
                end else if (!dir_act_reg) begin
                    act.a = (pwm_state_reg == CCPB_PWM_RUN);
                    act.d = raw_pwm;
                end else begin
                    act.c = (pwm_state_reg == CCPB_PWM_RUN);
                    act.b = raw_pwm;
                end
            end
        endcase
    end

    // pins: polarity per pair in pwm, compare latch otherwise
    // polarity is applied live; software changes it only with drivers off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else if (pwm_mode) begin
            pin_out.a <= act.a ^ mode[1];
            pin_out.c <= act.c ^ mode[1];
            pin_out.b <= act.b ^ mode[0];
            pin_out.d <= act.d ^ mode[0];
            pin_oe <= use_pins & ~{dir_reg[0], dir_reg[1], dir_reg[2], dir_reg[3]};
        end else begin
            pin_out <= {cmp_latch_reg, 3'b000};
            // soft interrupt mode hands the pin back to the port
            pin_oe <= {cmp_mode && (mode != CCPB_MODE_SOFT) && !dir_reg[0], 3'b000};
        end
    end

    // flags out as plain levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            module_event_flag <= 1'b0;
            period_timer_flag <= 1'b0;
        end else begin
            module_event_flag <= evt_flag_reg;
            period_timer_flag <= per_flag_reg;
        end
    end

endmodule

//--- common/ccpb_pkg.sv
// ============================================================
// shared constants and types for the compare / bridge pwm block
package ccpb_pkg;

    // ============================================================
    // register offsets on the plain register port
    localparam logic [3:0] CCPB_ADDR_CTRL = 4'h0;   // module_control_register
    localparam logic [3:0] CCPB_ADDR_CMP_LO = 4'h1; // compare_value_pair low byte
    localparam logic [3:0] CCPB_ADDR_CMP_HI = 4'h2; // compare_value_pair high byte
    localparam logic [3:0] CCPB_ADDR_DUTY = 4'h3;   // duty bits 9:2
    localparam logic [3:0] CCPB_ADDR_PERIOD = 4'h4; // period of the period_timer
    localparam logic [3:0] CCPB_ADDR_DEAD = 4'h5;   // dead_band_register
    localparam logic [3:0] CCPB_ADDR_STEER = 4'h6;  // pulse steering enables
    localparam logic [3:0] CCPB_ADDR_TCFG = 4'h7;   // timer configuration
    localparam logic [3:0] CCPB_ADDR_DIR = 4'h8;    // pin_direction_bits
    localparam logic [3:0] CCPB_ADDR_STAT = 4'h9;   // sticky flags, write one to clear
    localparam logic [3:0] CCPB_ADDR_TCNT = 4'hA;   // period_timer count, read only

    // ============================================================
    // field positions
    localparam int CCPB_CTRL_CFG_LSB = 6;     // output_config_field 7:6
    localparam int CCPB_CTRL_DLSB_LSB = 4;    // duty bits 1:0 at 5:4
    localparam int CCPB_TCFG_ON = 3;          // period timer runs
    localparam int CCPB_TCFG_SEL = 2;         // 0 time_base_one, 1 time_base_three
    localparam int CCPB_STAT_EVT = 0;         // module_event_flag
    localparam int CCPB_STAT_PER = 1;         // period_timer_flag

    // ============================================================
    // reset values
    localparam logic [7:0] CCPB_RST_ZERO = 8'h00;
    localparam logic [7:0] CCPB_RST_PERIOD = 8'hFF;
    localparam logic [3:0] CCPB_RST_DIR = 4'hF;     // all pins inputs

    // ============================================================
    // mode_select_field codes
    localparam logic [3:0] CCPB_MODE_OFF = 4'h0;
    localparam logic [3:0] CCPB_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] CCPB_MODE_SET = 4'h8;
    localparam logic [3:0] CCPB_MODE_CLEAR = 4'h9;
    localparam logic [3:0] CCPB_MODE_SOFT = 4'hA;
    localparam logic [3:0] CCPB_MODE_TRIG = 4'hB;

    // output_config_field codes
    localparam logic [1:0] CCPB_CFG_SINGLE = 2'h0;
    localparam logic [1:0] CCPB_CFG_FWD = 2'h1;
    localparam logic [1:0] CCPB_CFG_HALF = 2'h2;
    localparam logic [1:0] CCPB_CFG_REV = 2'h3;

    // pwm start-up sequencing
    typedef enum logic [1:0] {
        CCPB_PWM_IDLE = 2'b00,
        CCPB_PWM_WAIT = 2'b01,
        CCPB_PWM_RUN = 2'b10
    } ccpb_pwm_e;

    // the four bridge outputs travel together
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ccpb_pins_s;

endpackage

//--- rtl/ccpb_period_base.sv
`timescale 1ns/10ps
// ============================================================
// period timer with prescaler, forming the 10-bit pwm time base
module ccpb_period_base (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [7:0] period,
    input wire logic [1:0] presc_sel,
    // time base
    output logic [7:0] count,
    output logic [9:0] time_base,
    output logic period_start,
    output logic early_window
);
    import ccpb_pkg::*;

    logic [5:0] pc_reg;   // sub-count of oscillator ticks
    logic [2:0] shift;    // log2 of prescale value
    logic [5:0] pc_max;
    logic [5:0] last_part;

    // prescale 1, 4 or 16 times one instruction cycle
    always_comb begin
        shift = (presc_sel == 2'h0) ? 3'h0 : ((presc_sel == 2'h1) ? 3'h2 : 3'h4);
        pc_max = 6'(({4'h0, 2'h3} << shift) | ((6'h01 << shift) - 6'h01));
        last_part = 6'(6'h03 << shift);
    end

    // low bits are the quarter-cycle clock at prescale 1, else prescaler top bits
    assign time_base = {count, 2'(pc_reg >> shift)};
    // last prescale-value oscillator ticks of the period
    assign early_window = (count == period) && (pc_reg >= last_part);

    // counting; the start pulse marks the first tick of each period after a rollover, not of the first period after run
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= 6'h00;
            count <= 8'h00;
            period_start <= 1'b0;
        end else if (!run) begin
            pc_reg <= 6'h00;
            count <= 8'h00;
            period_start <= 1'b0;
        end else begin
            period_start <= 1'b0;
            if (pc_reg >= pc_max) begin
                pc_reg <= 6'h00;
                if (count == period) begin
                    count <= 8'h00;
                    period_start <= 1'b1;
                end else begin
                    count <= count + 8'h01;
                end
            end else begin
                pc_reg <= pc_reg + 6'h01;
            end
        end
    end

endmodule

//--- rtl/ccpb_dead_band.sv
`timescale 1ns/10ps
// ============================================================
// delays the inactive-to-active edge by a count of instruction cycles
module ccpb_dead_band (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic cycle_tick,
    input wire logic [6:0] delay,
    // signal
    input wire logic sig_in,
    output logic sig_out
);
    logic [6:0] cnt_reg;  // instruction cycles waited so far

    // a falling input cancels the wait, so a delay past the duty never goes active
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 7'h00;
            sig_out <= 1'b0;
        end else if (!enable || !sig_in) begin
            cnt_reg <= 7'h00;
            sig_out <= enable ? 1'b0 : sig_in;
        end else if (!sig_out) begin
            if (cnt_reg >= delay) begin
                sig_out <= 1'b1;
            end else if (cycle_tick) begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

endmodule

//--- verification/ccpb_top_checker.sv
`timescale 1ns/10ps
// ============================================================
// port checker: trigger pulses, sticky flags, read data
module ccpb_top_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port and flags
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic module_event_flag,
    input wire logic period_timer_flag,
    // trigger side
    input wire logic adc_enabled,
    input wire logic clear_time_base_one,
    input wire logic clear_time_base_three,
    input wire logic adc_start
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a flag may only drop after a write to clear it
    sequence wr_seen;
        $past(reg_wr, 1) || $past(reg_wr, 2) || $past(reg_wr, 3);
    endsequence
    adc_with_clr_a: assert property (
        adc_start |-> (clear_time_base_one || clear_time_base_three)) else $error("adc no clear");
    adc_needs_en_a: assert property (
        adc_start |-> $past(adc_enabled)) else $error("adc start while disabled");
    clr_one_once_a: assert property (
        clear_time_base_one |=> !clear_time_base_one) else $error("clear one too long");
    clr_three_once_a: assert property (
        clear_time_base_three |=> !clear_time_base_three) else $error("clear three too long");
    clr_exclusive_a: assert property (
        !(clear_time_base_one && clear_time_base_three)) else $error("both timers cleared");
    clr_sets_flag_a: assert property (
        clear_time_base_one |=> module_event_flag) else $error("no event flag");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
    evt_sticky_a: assert property (
        $fell(module_event_flag) |-> wr_seen) else $error("event flag dropped");
    per_sticky_a: assert property (
        $fell(period_timer_flag) |-> wr_seen) else $error("period flag dropped");
endmodule
bind ccpb_top ccpb_top_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .module_event_flag(module_event_flag),
    .period_timer_flag(period_timer_flag), .adc_enabled(adc_enabled),
    .clear_time_base_one(clear_time_base_one), .clear_time_base_three(clear_time_base_three),
    .adc_start(adc_start));

//--- verification/ccpb_bridge_model.sv
`timescale 1ns/10ps
// ============================================================
// power stage: undriven gates fall to the pull-down level
module ccpb_bridge_model (
    // pins from the block
    input wire ccpb_pkg::ccpb_pins_s pin_out,
    input wire ccpb_pkg::ccpb_pins_s pin_oe,
    // switch gates and leg short
    output logic [3:0] gate,
    output logic shoot
);
    assign gate = pin_out & pin_oe; // released pins read low
    assign shoot = (gate[3] & gate[2]) | (gate[1] & gate[0]); // a/b and c/d share a leg
endmodule

//--- verification/tb_compare_and_bridge_pwm.sv
`timescale 1ns/10ps
// ============================================================
// bench: compare actions, special trigger, full bridge
module tb_compare_and_bridge_pwm;
    import ccpb_pkg::*;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, adc_en = 1, clr1, clr3, adc, evt, per, shoot;
    logic [3:0] reg_addr = 0, gate;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [15:0] tb1 = 0, tb3 = 0;
    ccpb_pins_s pin_out, pin_oe;
    int n_errors = 0, total_checks = 0, n_clr = 0, n_adc = 0, cyc = 0;
    always #12.5 sys_clk = ~sys_clk;
    ccpb_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .time_base_one(tb1),
        .time_base_three(tb3), .adc_enabled(adc_en), .clear_time_base_one(clr1),
        .clear_time_base_three(clr3), .adc_start(adc), .module_event_flag(evt),
        .period_timer_flag(per), .pin_out(pin_out), .pin_oe(pin_oe));
    ccpb_bridge_model u_stage (.pin_out(pin_out), .pin_oe(pin_oe), .gate(gate), .shoot(shoot));
    // pulse counters and hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        n_clr <= n_clr + int'(clr1) + 16 * int'(clr3); // timer three counts in the upper nibble
        n_adc <= n_adc + int'(adc);
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end
    task wrap_up;
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    // both timers step on sys_clk, never asynchronously, then sit on the compare value
    task ramp;
        for (int i = 0; i < 14; i++) begin
            @(posedge sys_clk);
            tb1 <= (i < 5) ? 16'(i) : 16'h0005;
            tb3 <= (i < 5) ? 16'(i) : 16'h0005;
        end
    endtask
    task t_trigger;
        int c0;
        int a0;
        wr(CCPB_ADDR_CMP_LO, 8'h05);
        wr(CCPB_ADDR_CMP_HI, 8'h00);
        wr(CCPB_ADDR_CTRL, {4'h0, CCPB_MODE_TRIG});
        c0 = n_clr;
        a0 = n_adc;
        ramp();
        chk("timer clears", 8'h01, 8'(n_clr - c0));
        chk("adc starts", 8'h01, 8'(n_adc - a0));
        chk("event flag", 8'h01, {7'h0, evt});
        @(posedge sys_clk);
        reg_rd <= 1;
        reg_addr <= CCPB_ADDR_STAT;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 chk("status", 8'h01, reg_rdata);
        wr(CCPB_ADDR_STAT, 8'h03);
        // second round on timer three with the converter switched off
        adc_en <= 1'b0;
        wr(CCPB_ADDR_TCFG, 8'h04);
        c0 = n_clr;
        a0 = n_adc;
        ramp();
        chk("timer three clears", 8'h10, 8'(n_clr - c0));
        chk("adc held off", 8'h00, 8'(n_adc - a0));
        wr(CCPB_ADDR_TCFG, 8'h00);
    endtask
    task t_compare;
        logic [3:0] m [3] = '{CCPB_MODE_SET, CCPB_MODE_CLEAR, CCPB_MODE_TOGGLE};
        logic e [3] = '{1'b1, 1'b0, 1'b1};
        wr(CCPB_ADDR_DIR, 8'h0E);
        for (int k = 0; k < 3; k++) begin
            wr(CCPB_ADDR_CTRL, 8'h00);
            // a count already on the compare value would match as the mode lands
            tb1 <= 16'h0000;
            wr(CCPB_ADDR_CTRL, {4'h0, m[k]});
            repeat (2) @(posedge sys_clk);
            chk("start level", {7'h0, !e[k]}, {7'h0, pin_out.a});
            ramp();
            chk("compare pin", {7'h0, e[k]}, {7'h0, pin_out.a});
        end
        wr(CCPB_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge sys_clk);
        chk("latch cleared", 8'h00, {7'h0, pin_out.a});
        wr(CCPB_ADDR_CTRL, {4'h0, CCPB_MODE_SOFT});
        repeat (3) @(posedge sys_clk);
        chk("soft pin drive", 8'h00, {7'h0, pin_oe.a});
    endtask
    task t_bridge;
        wr(CCPB_ADDR_DIR, 8'h0F);
        wr(CCPB_ADDR_PERIOD, 8'h03);
        wr(CCPB_ADDR_DUTY, 8'h01);
        wr(CCPB_ADDR_TCFG, 8'h08);
        wr(CCPB_ADDR_CTRL, {CCPB_CFG_FWD, 2'b00, 4'hC});
        repeat (40) @(posedge sys_clk);
        chk("period flag", 8'h01, {7'h0, per});
        // drivers go on only once polarity is set and a full period has run
        wr(CCPB_ADDR_DIR, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk("forward a b c", 8'h04, {5'h0, gate[3:1]});
        wr(CCPB_ADDR_CTRL, {CCPB_CFG_REV, 2'b00, 4'hC});
        repeat (40) @(posedge sys_clk);
        chk("reverse a c d", 8'h02, {5'h0, pin_out.a, pin_out.c, pin_out.d});
        chk("leg short", 8'h00, {7'h0, shoot});
        wr(CCPB_ADDR_STAT, 8'h02);
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1;
        t_trigger();
        t_compare();
        t_bridge();
        wrap_up();
    end
endmodule
